// ===== design/bhcf_core.v
// Purpose: Branch history recorder and counter freeze on monitor interrupt.
// Assumes: Register port is a simple address/strobe port on the core clock;
//          all event inputs come from logic on the same clock.
// Notes:   Read data appears one cycle after the read strobe.
//
// Summary of operation
// - Freeze controls exist only when monitor version is at least 2.
// - Debug bit 11 freezes branch history on a monitor interrupt.
// - Versions 2 and 3 freeze history by clearing debug bit 0.
// - Version 4 and up set history frozen flag, bit 0 untouched.
// - Debug bit 12 freezes performance counters on a monitor interrupt.
// - Legacy counter freeze clears global enable, general and fixed counters.
// - Streamlined counter freeze sets counters frozen flag, enable untouched.
// - General counter overflow triggers only with event select bit 20.
// - Fixed counter overflow triggers only with its field bit 3.
// - Sampling or branch store buffer threshold also triggers a freeze.
// - Writing overflow reset clears the matching status bits.
// - Stack holds N source/target pairs, N is 4, 8, 16 or 32.
// - Each instruction pointer change is recorded in the stack while recording runs.
// - Low bits of top pointer index the newest record, 0 to N-1.
// - Recording runs while debug bit 0 is set and the history frozen flag is clear.
`timescale 1ns/1ps
`default_nettype none
`include "bhcf_defs.vh"

module bhcf_core #(
   parameter [7:0] MON_VERSION = 8'h04,
   parameter       NGP         = 4,
   parameter       NFIX        = 3,
   parameter       CW          = 48,
   parameter       HIST_DEPTH  = 32,
   parameter       PW          = 5
) (
   input  wire        core_clk_i,          // Core clock, 40 MHz
   input  wire        resetn_i,            // Async reset, active low
   input  wire [11:0] msr_addr_i,          // Register address
   input  wire        msr_wr_i,            // Write strobe
   input  wire        msr_rd_i,            // Read strobe
   input  wire [63:0] msr_wdata_i,         // Write data
   output wire [63:0] msr_rdata_o,         // Read data, registered
   output wire        msr_rvalid_o,        // Read data valid pulse
   input  wire        br_valid_i,          // Pointer change this cycle
   input  wire [63:0] br_src_i,            // Source address
   input  wire [63:0] br_dst_i,            // Target address
   input  wire [NGP-1:0]  gp_evt_i,        // General counter events
   input  wire [NFIX-1:0] fx_evt_i,        // Fixed counter events
   input  wire        smp_buf_thr_i,       // Sampling buffer at threshold
   input  wire        brs_buf_thr_i,       // Branch store at threshold
   output wire        monitor_interrupt_o, // Monitor interrupt pulse
   output wire        history_frozen_o,    // History frozen flag
   output wire        counters_frozen_o,   // Counters frozen flag
   output wire        branch_history_enable_o // Debug bit 0
);

   localparam FRZ_OK = (MON_VERSION >= `BHCF_VER_FRZ_MIN);
   localparam STREAM = (MON_VERSION >= `BHCF_VER_STREAM_MIN);
   localparam LEGACY = FRZ_OK && !STREAM;

   localparam [31:0] SRC_END = `BHCF_ADR_SRC_BASE + HIST_DEPTH;
   localparam [31:0] DST_END = `BHCF_ADR_DST_BASE + HIST_DEPTH;

   reg  [63:0] dbg_r;
   reg  [63:0] dbg_nxt;
   reg  [63:0] glob_en_r;
   reg  [63:0] glob_en_nxt;
   reg  [63:0] fix_ctl_r;
   reg  [NGP-1:0]  gp_ovf_r;
   reg  [NFIX-1:0] fx_ovf_r;
   reg         hist_frz_r;
   reg         counters_frozen_flag_r;
   reg         smp_r;
   reg         brs_r;
   reg  [63:0] rdata_r;
   reg  [63:0] rd_nxt;
   reg         rvalid_r;
   reg         irq_r;
   reg  [63:0] status_w;
   integer     k;

   wire [NGP-1:0]  gp_ovf_ev;
   wire [NGP-1:0]  gp_pmi_en;
   wire [NGP-1:0]  gp_ev_hit;
   wire [NGP-1:0]  gp_ct_hit;
   wire [63:0]     gp_evsel_w [0:NGP-1];
   wire [63:0]     gp_cnt_w   [0:NGP-1];
   wire [NFIX-1:0] fx_ovf_ev;
   wire [NFIX-1:0] fx_pmi_en;
   wire [NFIX-1:0] fx_ct_hit;
   wire [63:0]     fx_cnt_w   [0:NFIX-1];

   wire        wr_dbg;
   wire        wr_glob;
   wire        wr_fix;
   wire        wr_rst;
   wire        irq_cond;
   wire        rec;
   wire        src_hit;
   wire        dst_hit;
   wire [11:0] src_off;
   wire [11:0] dst_off;
   wire [PW-1:0] rd_idx;
   wire [63:0] rd_src;
   wire [63:0] rd_dst;
   wire [PW-1:0] top_ptr;
   wire [63:0] frz_wmask;

   assign wr_dbg  = msr_wr_i & (msr_addr_i == `BHCF_ADR_DBG_CTL);
   assign wr_glob = msr_wr_i & (msr_addr_i == `BHCF_ADR_GLOB_EN);
   assign wr_fix  = msr_wr_i & (msr_addr_i == `BHCF_ADR_FIX_CTL);
   assign wr_rst  = msr_wr_i & (msr_addr_i == `BHCF_ADR_OVF_RST);

   // General-purpose counters, one per generate entry
   genvar gi;
   generate
      for (gi = 0; gi < NGP; gi = gi + 1) begin : g_gp
         localparam [31:0] A_EV = `BHCF_ADR_EVSEL_BASE + gi;
         localparam [31:0] A_CT = `BHCF_ADR_GPCNT_BASE + gi;
         reg  [63:0]   evsel_r;
         reg  [CW-1:0] cnt_r;
         wire          inc;
         assign inc = gp_evt_i[gi] & evsel_r[`BHCF_EVSEL_EN] &
                      glob_en_r[gi] & ~counters_frozen_flag_r;
         assign gp_ev_hit[gi] = (msr_addr_i == A_EV[11:0]);
         assign gp_ct_hit[gi] = (msr_addr_i == A_CT[11:0]);
         always @(posedge core_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               evsel_r <= `BHCF_RST_EVSEL;
               cnt_r   <= {CW{1'b0}};
            end else begin
               if (msr_wr_i && gp_ev_hit[gi]) begin
                  evsel_r <= msr_wdata_i;
               end
               // A software write takes priority over counting
               if (msr_wr_i && gp_ct_hit[gi]) begin
                  cnt_r <= msr_wdata_i[CW-1:0];
               end else if (inc) begin
                  cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
               end
            end
         end
         assign gp_ovf_ev[gi] = inc & ~(msr_wr_i & gp_ct_hit[gi]) & (&cnt_r);
         assign gp_pmi_en[gi]  = evsel_r[`BHCF_EVSEL_INT];
         assign gp_evsel_w[gi] = evsel_r;
         assign gp_cnt_w[gi]   = {{(64-CW){1'b0}}, cnt_r};
      end
   endgenerate

   // Fixed-function counters
   genvar fj;
   generate
      for (fj = 0; fj < NFIX; fj = fj + 1) begin : g_fx
         localparam [31:0] A_CT = `BHCF_ADR_FXCNT_BASE + fj;
         reg  [CW-1:0] cnt_r;
         wire [3:0]    fld;
         wire          inc;
         assign fld = fix_ctl_r[fj*`BHCF_FIX_FW +: `BHCF_FIX_FW];
         assign inc = fx_evt_i[fj] & (|fld[1:0]) &
                      glob_en_r[`BHCF_ST_FIX_BASE + fj] & ~counters_frozen_flag_r;
         assign fx_ct_hit[fj] = (msr_addr_i == A_CT[11:0]);
         always @(posedge core_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               cnt_r <= {CW{1'b0}};
            end else if (msr_wr_i && fx_ct_hit[fj]) begin
               cnt_r <= msr_wdata_i[CW-1:0];
            end else if (inc) begin
               cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
            end
         end
         assign fx_ovf_ev[fj] = inc & ~(msr_wr_i & fx_ct_hit[fj]) & (&cnt_r);
         assign fx_pmi_en[fj] = fld[`BHCF_FIX_INT];
         assign fx_cnt_w[fj]  = {{(64-CW){1'b0}}, cnt_r};
      end
   endgenerate

   assign irq_cond = (|(gp_ovf_ev & gp_pmi_en)) | (|(fx_ovf_ev & fx_pmi_en)) |
                     smp_buf_thr_i | brs_buf_thr_i;

   // Debug control and global enable next state
   always @* begin
      dbg_nxt     = dbg_r;
      glob_en_nxt = glob_en_r;
      if (wr_dbg) begin
         dbg_nxt = 64'h0000000000000000;
         dbg_nxt[`BHCF_DBG_HIST_EN] = msr_wdata_i[`BHCF_DBG_HIST_EN];
         // freeze bits absent below version 2
         dbg_nxt[`BHCF_DBG_HIST_FRZ] = FRZ_OK &&
                                      msr_wdata_i[`BHCF_DBG_HIST_FRZ];
         dbg_nxt[`BHCF_DBG_COUNTERS_FROZEN_FLAG]  = FRZ_OK &&
                                      msr_wdata_i[`BHCF_DBG_COUNTERS_FROZEN_FLAG];
      end
      if (wr_glob) begin
         glob_en_nxt = msr_wdata_i;
      end
      // legacy clears enable
      // Hardware clear beats a same-cycle write so the freeze is not lost
      if (LEGACY && irq_cond && dbg_r[`BHCF_DBG_HIST_FRZ]) begin
         dbg_nxt[`BHCF_DBG_HIST_EN] = 1'b0;
      end
      if (LEGACY && irq_cond && dbg_r[`BHCF_DBG_COUNTERS_FROZEN_FLAG]) begin
         glob_en_nxt = 64'h0000000000000000;
      end
   end

   // reset write mask, set wins over clear
   assign frz_wmask = wr_rst ? msr_wdata_i : 64'h0000000000000000;

   // Register state
   always @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         dbg_r      <= `BHCF_RST_DBG;
         glob_en_r  <= `BHCF_RST_GLOB_EN;
         fix_ctl_r  <= `BHCF_RST_FIX_CTL;
         gp_ovf_r   <= {NGP{1'b0}};
         fx_ovf_r   <= {NFIX{1'b0}};
         hist_frz_r <= 1'b0;
         counters_frozen_flag_r  <= 1'b0;
         smp_r      <= 1'b0;
         brs_r      <= 1'b0;
         irq_r      <= 1'b0;
      end else begin
         dbg_r     <= dbg_nxt;
         glob_en_r <= glob_en_nxt;
         if (wr_fix) begin
            fix_ctl_r <= msr_wdata_i;
         end
         gp_ovf_r <= (gp_ovf_r & ~frz_wmask[NGP-1:0]) | gp_ovf_ev;
         fx_ovf_r <= (fx_ovf_r & ~frz_wmask[`BHCF_ST_FIX_BASE +: NFIX]) |
                     fx_ovf_ev;
         smp_r <= (smp_r & ~frz_wmask[`BHCF_ST_SMP_BUF]) | smp_buf_thr_i;
         brs_r <= (brs_r & ~frz_wmask[`BHCF_ST_BRS_BUF]) | brs_buf_thr_i;
         hist_frz_r <= (hist_frz_r & ~frz_wmask[`BHCF_ST_HIST_FRZ]) |
                       (STREAM && irq_cond && dbg_r[`BHCF_DBG_HIST_FRZ]);
         counters_frozen_flag_r <= (counters_frozen_flag_r & ~frz_wmask[`BHCF_ST_COUNTERS_FROZEN_FLAG]) |
                      (STREAM && irq_cond && dbg_r[`BHCF_DBG_COUNTERS_FROZEN_FLAG]);
         irq_r <= irq_cond;
      end
   end

   assign rec = br_valid_i & dbg_r[`BHCF_DBG_HIST_EN] & ~hist_frz_r;

   // Stack read decode
   assign src_hit = (msr_addr_i >= `BHCF_ADR_SRC_BASE) &&
                    (msr_addr_i < SRC_END[11:0]);
   assign dst_hit = (msr_addr_i >= `BHCF_ADR_DST_BASE) &&
                    (msr_addr_i < DST_END[11:0]);
   assign src_off = msr_addr_i - `BHCF_ADR_SRC_BASE;
   assign dst_off = msr_addr_i - `BHCF_ADR_DST_BASE;
   assign rd_idx  = src_hit ? src_off[PW-1:0] : dst_off[PW-1:0];

   bhcf_hist_stack #(
      .HIST_DEPTH (HIST_DEPTH),
      .PW         (PW),
      .AW         (64)
   ) u_stack (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .rec_i      (rec),
      .src_i      (br_src_i),
      .dst_i      (br_dst_i),
      .rd_idx_i   (rd_idx),
      .rd_src_o   (rd_src),
      .rd_dst_o   (rd_dst),
      .top_o      (top_ptr)
   );

   always @* begin
      status_w = 64'h0000000000000000;
      status_w[NGP-1:0] = gp_ovf_r;
      status_w[`BHCF_ST_FIX_BASE +: NFIX] = fx_ovf_r;
      status_w[`BHCF_ST_HIST_FRZ] = hist_frz_r;
      status_w[`BHCF_ST_COUNTERS_FROZEN_FLAG]  = counters_frozen_flag_r;
      status_w[`BHCF_ST_BRS_BUF]  = brs_r;
      status_w[`BHCF_ST_SMP_BUF]  = smp_r;
   end

   // Read mux; unmapped and write-only addresses read zero
   always @* begin
      rd_nxt = 64'h0000000000000000;
      if (msr_addr_i == `BHCF_ADR_DBG_CTL) begin
         rd_nxt = dbg_r;
      end else if (msr_addr_i == `BHCF_ADR_GLOB_EN) begin
         rd_nxt = glob_en_r;
      end else if (msr_addr_i == `BHCF_ADR_FIX_CTL) begin
         rd_nxt = fix_ctl_r;
      end else if (msr_addr_i == `BHCF_ADR_STATUS) begin
         rd_nxt = status_w;
      end else if (msr_addr_i == `BHCF_ADR_TOP_PTR) begin
         rd_nxt[PW-1:0] = top_ptr;
      end else if (src_hit) begin
         rd_nxt = rd_src;
      end else if (dst_hit) begin
         rd_nxt = rd_dst;
      end
      for (k = 0; k < NGP; k = k + 1) begin
         if (gp_ev_hit[k]) begin
            rd_nxt = gp_evsel_w[k];
         end
         if (gp_ct_hit[k]) begin
            rd_nxt = gp_cnt_w[k];
         end
      end
      for (k = 0; k < NFIX; k = k + 1) begin
         if (fx_ct_hit[k]) begin
            rd_nxt = fx_cnt_w[k];
         end
      end
   end

   // Registered read answer
   always @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_r  <= 64'h0000000000000000;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= msr_rd_i;
         if (msr_rd_i) begin
            rdata_r <= rd_nxt;
         end
      end
   end

   assign msr_rdata_o             = rdata_r;
   assign msr_rvalid_o            = rvalid_r;
   assign monitor_interrupt_o     = irq_r;
   assign history_frozen_o        = hist_frz_r;
   assign counters_frozen_o       = counters_frozen_flag_r;
   assign branch_history_enable_o = dbg_r[`BHCF_DBG_HIST_EN];

endmodule

`default_nettype wire

// ===== shared/bhcf_defs.vh
// Purpose: Constants for the branch history and counter freeze block.
// Assumes: 12-bit register addresses, 64-bit register data.
// Notes:   Addresses other than status and overflow reset are local picks.
`ifndef BHCF_DEFS_VH
`define BHCF_DEFS_VH

// Register addresses
`define BHCF_ADR_DBG_CTL      12'h0e0
`define BHCF_ADR_GLOB_EN      12'h0e1
`define BHCF_ADR_TOP_PTR      12'h0e2
`define BHCF_ADR_FIX_CTL      12'h0e3
`define BHCF_ADR_EVSEL_BASE   12'h0f0
`define BHCF_ADR_GPCNT_BASE   12'h100
`define BHCF_ADR_FXCNT_BASE   12'h110
`define BHCF_ADR_SRC_BASE     12'h200
`define BHCF_ADR_DST_BASE     12'h240
`define BHCF_ADR_STATUS       12'h38e
`define BHCF_ADR_OVF_RST      12'h390

// Debug control fields
`define BHCF_DBG_HIST_EN      0
`define BHCF_DBG_HIST_FRZ     11
`define BHCF_DBG_COUNTERS_FROZEN_FLAG      12

// Event select and fixed control fields
`define BHCF_EVSEL_INT        20
`define BHCF_EVSEL_EN         22
`define BHCF_FIX_FW           4
`define BHCF_FIX_INT          3

// Global status and global enable layout
`define BHCF_ST_FIX_BASE      32
`define BHCF_ST_HIST_FRZ      58
`define BHCF_ST_COUNTERS_FROZEN_FLAG       59
`define BHCF_ST_BRS_BUF       61
`define BHCF_ST_SMP_BUF       62

// Reset values
`define BHCF_RST_DBG          64'h0000000000000000
`define BHCF_RST_GLOB_EN      64'h0000000000000000
`define BHCF_RST_FIX_CTL      64'h0000000000000000
`define BHCF_RST_EVSEL        64'h0000000000000000

// Monitoring version thresholds
`define BHCF_VER_FRZ_MIN      8'h02
`define BHCF_VER_STREAM_MIN   8'h04

// Read latency in clock cycles
`define BHCF_RD_LAT           1

`endif

// ===== design/bhcf_hist_stack.v
// Purpose: Circular stack of branch source/target pairs with top pointer.
// Assumes: Depth is a power of two (4, 8, 16 or 32).
// Notes:   Entries are not reset; only the pointer has a reset value.
`timescale 1ns/1ps
`default_nettype none

module bhcf_hist_stack #(
   parameter HIST_DEPTH = 32,
   parameter PW         = 5,
   parameter AW         = 64
) (
   input  wire          core_clk_i,  // Core clock
   input  wire          resetn_i,    // Async reset, active low
   input  wire          rec_i,       // Store one record this cycle
   input  wire [AW-1:0] src_i,       // Branch source address
   input  wire [AW-1:0] dst_i,       // Branch target address
   input  wire [PW-1:0] rd_idx_i,    // Entry to read
   output wire [AW-1:0] rd_src_o,    // Source of read entry
   output wire [AW-1:0] rd_dst_o,    // Target of read entry
   output wire [PW-1:0] top_o        // Index of most recent record
);

   reg [AW-1:0] src_mem [0:HIST_DEPTH-1];
   reg [AW-1:0] dst_mem [0:HIST_DEPTH-1];
   reg [PW-1:0] top_r;
   wire [PW-1:0] top_nxt;

   // advance modulo depth
   // Power-of-two depth lets the pointer wrap by plain overflow
   assign top_nxt = top_r + {{(PW-1){1'b0}}, 1'b1};

   always @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         top_r <= {PW{1'b0}};
      end else if (rec_i) begin
         top_r <= top_nxt;
      end
   end

   always @(posedge core_clk_i) begin
      if (rec_i) begin
         src_mem[top_nxt] <= src_i;
         dst_mem[top_nxt] <= dst_i;
      end
   end

   assign rd_src_o = src_mem[rd_idx_i];
   assign rd_dst_o = dst_mem[rd_idx_i];
   assign top_o    = top_r;

endmodule

`default_nettype wire

// ===== dv/bhcf_core_asserts.sv
// Purpose: Port-level checks for the branch history and freeze block.
// Assumes: One core clock domain, asynchronous active-low reset.
// Notes:   Overflow causes sit inside the block; the bench judges those.
`timescale 1ns/1ps
`default_nettype none
module bhcf_core_asserts #(
   parameter [7:0] MON_VERSION = 8'h04
) (
   input wire logic        core_clk_i,              // Core clock
   input wire logic        resetn_i,                // Reset, active low
   input wire logic [11:0] msr_addr_i,              // Register address
   input wire logic        msr_wr_i,                // Write strobe
   input wire logic        msr_rd_i,                // Read strobe
   input wire logic [63:0] msr_wdata_i,             // Write data
   input wire logic [63:0] msr_rdata_o,             // Read data
   input wire logic        msr_rvalid_o,            // Read valid
   input wire logic        smp_buf_thr_i,           // Sampling threshold
   input wire logic        brs_buf_thr_i,           // Branch store threshold
   input wire logic        monitor_interrupt_o,     // Interrupt pulse
   input wire logic        history_frozen_o,        // History frozen flag
   input wire logic        counters_frozen_o,       // Counters frozen flag
   input wire logic        branch_history_enable_o  // Debug bit 0
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!resetn_i);

   // Overflow reset write, the only way a frozen flag may drop
   wire clr_w = msr_wr_i && (msr_addr_i == 12'h390);

   a_read_answer: assert property (msr_rd_i |=> msr_rvalid_o)
      else $error("read not answered one cycle later");
   a_valid_cause: assert property (!msr_rd_i |=> !msr_rvalid_o)
      else $error("read valid without a read");
   a_hist_hold: assert property (
      history_frozen_o && !(clr_w && msr_wdata_i[58]) |=> history_frozen_o)
      else $error("history frozen flag dropped without reset write");
   a_ctr_hold: assert property (
      counters_frozen_o && !(clr_w && msr_wdata_i[59]) |=> counters_frozen_o)
      else $error("counters frozen flag dropped without reset write");
   a_enable_kept: assert property (
      MON_VERSION >= 8'h04 && !(msr_wr_i && msr_addr_i == 12'h0e0)
      |=> $stable(branch_history_enable_o))
      else $error("history enable changed without a write");
   a_thr_irq: assert property (
      smp_buf_thr_i || brs_buf_thr_i |=> monitor_interrupt_o)
      else $error("threshold did not raise the interrupt");
   a_freeze_irq: assert property (
      $rose(history_frozen_o) || $rose(counters_frozen_o)
      |-> monitor_interrupt_o)
      else $error("freeze flag rose without interrupt");
   a_old_noflag: assert property (
      MON_VERSION < 8'h04 |-> !history_frozen_o && !counters_frozen_o)
      else $error("frozen flag set below streamlined version");
   a_status_flags: assert property (
      msr_rd_i && msr_addr_i == 12'h38e |=>
      msr_rdata_o[59:58] == $past({counters_frozen_o, history_frozen_o}))
      else $error("status read disagrees with frozen flags");
   a_reset_reads0: assert property (
      msr_rd_i && msr_addr_i == 12'h390 |=> msr_rdata_o == 64'h0)
      else $error("overflow reset register read not zero");
endmodule
bind bhcf_core bhcf_core_asserts #(.MON_VERSION(MON_VERSION)) u_chk (
   .core_clk_i, .resetn_i, .msr_addr_i, .msr_wr_i, .msr_rd_i, .msr_wdata_i,
   .msr_rdata_o, .msr_rvalid_o, .smp_buf_thr_i, .brs_buf_thr_i,
   .monitor_interrupt_o, .history_frozen_o, .counters_frozen_o,
   .branch_history_enable_o);
`default_nettype wire

// ===== dv/bhcf_core_tb_top.sv
// Purpose: Self-checking bench for the branch history and freeze block.
// Assumes: Streamlined version, four-entry stack to exercise wrap-around;
//          a legacy-version twin shares the stimulus for the legacy freeze.
// Notes:   Reads are queued by the driver and matched by a monitor.
`timescale 1ns/1ps
`default_nettype none
module bhcf_core_tb_top;
   localparam DEP = 4;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [11:0] addr = 12'h000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [63:0] wd = 64'h0;
   logic [63:0] rdat;
   logic        rv;
   logic        bv = 1'b0;
   logic [63:0] bs = 64'h0;
   logic [63:0] bd = 64'h0;
   logic [3:0]  gev = 4'h0;
   logic [2:0]  fev = 3'h0;
   logic        smp = 1'b0;
   logic        brs = 1'b0;
   logic        irq;
   logic        hfz;
   logic        cfz;
   logic        hen;
   logic [63:0] rdat_l;
   logic        hen_l;
   int          errors = 0;
   int          num_checks = 0;
   int          top = 0;
   bit   [31:0] seed = 32'hebca9a35;
   string       nq[$];
   logic [63:0] eq[$];
   logic [63:0] src_m [DEP];
   logic [63:0] dst_m [DEP];
   logic [11:0] ra [6] = '{12'h0e0, 12'h0e1, 12'h0e2,
                           12'h38e, 12'h390, 12'h7ff};

   // Free-running core clock, 25 ns period
   always #12.5 clk = ~clk;

   bhcf_core #(.MON_VERSION(8'h04), .HIST_DEPTH(DEP), .PW(2)) uut (
      .core_clk_i(clk), .resetn_i(rst_n), .msr_addr_i(addr), .msr_wr_i(wr),
      .msr_rd_i(rd), .msr_wdata_i(wd), .msr_rdata_o(rdat), .msr_rvalid_o(rv),
      .br_valid_i(bv), .br_src_i(bs), .br_dst_i(bd), .gp_evt_i(gev),
      .fx_evt_i(fev), .smp_buf_thr_i(smp), .brs_buf_thr_i(brs),
      .monitor_interrupt_o(irq), .history_frozen_o(hfz),
      .counters_frozen_o(cfz), .branch_history_enable_o(hen));

   // Legacy twin: same inputs, its enable bit and held read data are judged
   bhcf_core #(.MON_VERSION(8'h03), .HIST_DEPTH(DEP), .PW(2)) uut_leg (
      .core_clk_i(clk), .resetn_i(rst_n), .msr_addr_i(addr), .msr_wr_i(wr),
      .msr_rd_i(rd), .msr_wdata_i(wd), .msr_rdata_o(rdat_l), .msr_rvalid_o(),
      .br_valid_i(bv), .br_src_i(bs), .br_dst_i(bd), .gp_evt_i(gev),
      .fx_evt_i(fev), .smp_buf_thr_i(smp), .brs_buf_thr_i(brs),
      .monitor_interrupt_o(), .history_frozen_o(),
      .counters_frozen_o(), .branch_history_enable_o(hen_l));

   function automatic bit [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic final_report();
      if (errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic wr_reg(logic [11:0] a, logic [63:0] d);
      @(negedge clk);
      addr = a;
      wd = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask

   // Note the expectation, strobe once, leave a gap for the monitor
   task automatic rd_reg(string nm, logic [11:0] a, logic [63:0] e);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      nq.push_back(nm);
      eq.push_back(e);
      @(negedge clk);
      rd = 1'b0;
      @(negedge clk);
   endtask

   // Back-to-back records; the model pointer moves only when kept
   task automatic branches(int n, bit take);
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         bv = 1'b1;
         bs = {xs(), xs()};
         bd = {xs(), xs()};
         if (take) begin
            top = (top + 1) % DEP;
            src_m[top] = bs;
            dst_m[top] = bd;
         end
      end
      @(negedge clk);
      bv = 1'b0;
      bs = ~bs;
   endtask

   // One event pulse, then watch five cycles for the interrupt
   task automatic pulse(int k, logic e);
      logic seen;
      seen = 1'b0;
      @(negedge clk);
      case (k)
         0: gev = 4'h1;
         1: fev = 3'h1;
         2: smp = 1'b1;
         default: brs = 1'b1;
      endcase
      repeat (5) begin
         @(negedge clk);
         gev = 4'h0;
         fev = 3'h0;
         smp = 1'b0;
         brs = 1'b0;
         if (irq === 1'b1)
            seen = 1'b1;
      end
      chk("irq", 64'(seen), 64'(e));
   endtask

   // Monitor: each read answer retires the oldest note
   always @(negedge clk) begin
      if (rv === 1'b1) begin
         if (eq.size() == 0)
            chk("unexpected read", 64'h1, 64'h0);
         else
            chk(nq.pop_front(), rdat, eq.pop_front());
      end
   end

   // Watchdog well beyond the few hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      final_report();
   end

   initial begin
      repeat (10) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      foreach (ra[i]) rd_reg("reset", ra[i], 64'h0);
      branches(2, 1'b0);
      rd_reg("top", 12'h0e2, 64'h0);
      wr_reg(12'h0e0, 64'h1801);
      rd_reg("dbg", 12'h0e0, 64'h1801);
      chk("hen", 64'(hen), 64'h1);
      branches(5, 1'b1);
      rd_reg("top", 12'h0e2, 64'(top));
      for (int n = 0; n < DEP; n++) begin
         rd_reg("src", 12'h200 + 12'(n), src_m[n]);
         rd_reg("dst", 12'h240 + 12'(n), dst_m[n]);
      end
      wr_reg(12'h0f0, 64'h500000);
      wr_reg(12'h0e1, 64'h1_0000_0001);
      wr_reg(12'h100, 64'hffff_ffff_ffff);
      pulse(0, 1'b1);
      chk("hfz", 64'(hfz), 64'h1);
      chk("cfz", 64'(cfz), 64'h1);
      rd_reg("status", 12'h38e, 64'h0c00_0000_0000_0001);
      rd_reg("dbg", 12'h0e0, 64'h1801);
      rd_reg("gen", 12'h0e1, 64'h1_0000_0001);
      chk("leg_gen", rdat_l, 64'h0);
      chk("leg_hen", 64'(hen_l), 64'h0);
      // Handler duties of the legacy variant; same values for the twin
      wr_reg(12'h0e0, 64'h1801);
      wr_reg(12'h0e1, 64'h1_0000_0001);
      rd_reg("gen", 12'h0e1, 64'h1_0000_0001);
      chk("leg_gen", rdat_l, 64'h1_0000_0001);
      chk("leg_hen", 64'(hen_l), 64'h1);
      branches(2, 1'b0);
      pulse(0, 1'b0);
      rd_reg("top", 12'h0e2, 64'(top));
      rd_reg("cnt", 12'h100, 64'h0);
      wr_reg(12'h390, 64'h0c00_0000_0000_0001);
      rd_reg("status", 12'h38e, 64'h0);
      chk("flags", {62'h0, cfz, hfz}, 64'h0);
      wr_reg(12'h0f0, 64'h400000);
      wr_reg(12'h100, 64'hffff_ffff_ffff);
      pulse(0, 1'b0);
      rd_reg("noint", 12'h38e, 64'h1);
      wr_reg(12'h390, 64'h1);
      for (int k = 0; k < 2; k++) begin
         wr_reg(12'h0e3, k ? 64'h9 : 64'h1);
         wr_reg(12'h110, 64'hffff_ffff_ffff);
         pulse(1, k[0]);
         rd_reg("fxst", 12'h38e,
                k ? 64'h0c00_0001_0000_0000 : 64'h1_0000_0000);
         wr_reg(12'h390, 64'hffff_ffff_ffff_ffff);
      end
      for (int k = 2; k < 4; k++) begin
         pulse(k, 1'b1);
         rd_reg("thr", 12'h38e, {1'b0, k == 2, k == 3, 3'b011, 58'h0});
         wr_reg(12'h390, {1'b0, k == 2, k == 3, 3'b001, 58'h0});
         rd_reg("part", 12'h38e, 64'h0800_0000_0000_0000);
         wr_reg(12'h390, 64'hffff_ffff_ffff_ffff);
      end
      branches(3, 1'b1);
      rd_reg("top", 12'h0e2, 64'(top));
      rd_reg("src", 12'h200 + 12'(top), src_m[top]);
      repeat (3) @(negedge clk);
      chk("pending", 64'(eq.size()), 64'h0);
      final_report();
   end
endmodule
`default_nettype wire
